/* File: pkg/scp_consts.vh */
// Constants for the system clock source and prescaler block
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCP_OFS_DIVIDER   8'h00
`define SCP_OFS_TRIM      8'h04
`define SCP_OFS_ASYNC     8'h08
`define SCP_OFS_STATUS    8'h0C

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define SCP_DIV_CE_BIT    7
`define SCP_DIV_CE_WORD   8'h80
`define SCP_ASY_OSC_BIT   0
`define SCP_ASY_EXT_BIT   1
`define SCP_ST_RUN_BIT    5
`define SCP_ST_PEND_BIT   4
`define SCP_ST_SRC_LSB    8
`define SCP_DIV_MAX_CODE  4'h8
`define SCP_DIV8_CODE     4'h3
`define SCP_DIV_RST       4'h0
`define SCP_TRIM_RST      8'h00

// ----------------------------------------------------------------
// Clock source codes and start-up codes
// ----------------------------------------------------------------
`define SCP_SRC_EXT       4'h0
`define SCP_SRC_RC        4'h2
`define SCP_SRC_LF        4'h3
`define SCP_SUT_BASE      2'h0
`define SCP_SUT_FAST      2'h1
`define SCP_SUT_SLOW      2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCP_CLK_MHZ       125
`define SCP_T_4P1MS_US    4100
`define SCP_T_4MS_US      4000
`define SCP_T_65MS_US     65000
`define SCP_BASE_CK       19
`define SCP_WAKE_CK       6
`define SCP_CE_CYCLES     4

`endif

/* File: hdl/scp_top.v */
// System clock source selection, start-up delay and protected prescaler
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.vh"

module scp_top #(
  parameter [23:0] DLY_4P1MS = `SCP_T_4P1MS_US * `SCP_CLK_MHZ,
  parameter [23:0] DLY_4MS = `SCP_T_4MS_US * `SCP_CLK_MHZ,
  parameter [23:0] DLY_65MS = `SCP_T_65MS_US * `SCP_CLK_MHZ
) (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Fuse array, static configuration
  input wire [3:0] clock_source_select_fuses,
  input wire [1:0] startup_time_fuses,
  input wire divide_by_eight_fuse,
  input wire reset_pin_disable_fuse,
  input wire clock_output_fuse,
  input wire [7:0] factory_trim,
  // Power manager
  input wire wake_req,
  output reg wake_done_q,
  output reg core_rst_n_q,
  // Source selection
  output wire src_rc_sel,
  output wire src_lf_sel,
  output wire src_ext_sel,
  output wire [7:0] rc_trim,
  // Divided system clock
  output wire sysclk_out,
  output reg sysclk_tick_q,
  // Clock output pin and its normal port function
  input wire gpio_out,
  input wire gpio_oe,
  output wire clock_output_pin_o,
  output wire clock_output_pin_oe,
  // Timer oscillator pin control
  output wire timer_osc_xtal_en,
  output wire timer_osc_ext_sel
);

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  // Fuses are internal static state on this clock, so no synchroniser
  assign src_rc_sel = (clock_source_select_fuses == `SCP_SRC_RC);
  assign src_lf_sel = (clock_source_select_fuses == `SCP_SRC_LF);
  assign src_ext_sel = (clock_source_select_fuses == `SCP_SRC_EXT);
  wire src_bad = ~(src_rc_sel | src_lf_sel | src_ext_sel);
  wire [1:0] src_code = src_bad ? 2'h3 :
                        src_ext_sel ? 2'h2 : (src_lf_sel ? 2'h1 : 2'h0);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  reg wr_q;
  reg rd_q;
  reg [7:0] addr_q;
  wire take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  wire wr_div = wr_q & (addr_q == `SCP_OFS_DIVIDER);
  wire wr_trim = wr_q & (addr_q == `SCP_OFS_TRIM);
  wire wr_async = wr_q & (addr_q == `SCP_OFS_ASYNC);
  wire [7:0] wd = hwdata[7:0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg init_q;
  reg ce_q;
  reg [2:0] ce_cnt_q;
  reg [3:0] sel_q;
  reg pend_q;
  reg [7:0] trim_q;
  reg osc_req_q;
  reg ext_req_q;
  wire apply;
  // Window length kept as a full word so the load below is cut on purpose
  wire [31:0] ce_last = `SCP_CE_CYCLES - 1;

  // An asynchronous reset may load only constants, so the fuse-based
  // select and the factory trim land on the first edge after release
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_q <= 1'b0;
      ce_q <= 1'b0;
      ce_cnt_q <= 3'h0;
      sel_q <= `SCP_DIV_RST;
      pend_q <= 1'b0;
      trim_q <= `SCP_TRIM_RST;
      osc_req_q <= 1'b0;
      ext_req_q <= 1'b0;
    end else if (!init_q) begin
      init_q <= 1'b1;
      trim_q <= factory_trim;
      if (divide_by_eight_fuse) begin
        sel_q <= `SCP_DIV8_CODE;
        pend_q <= 1'b1;
      end
    end else begin
      if (apply) begin
        pend_q <= 1'b0;
      end
      if (ce_q) begin
        if (ce_cnt_q == 3'h0) begin
          ce_q <= 1'b0;
        end else begin
          ce_cnt_q <= ce_cnt_q - 3'h1;
        end
      end
      if (wr_div) begin
        if (wd == `SCP_DIV_CE_WORD) begin
          // Rewrite inside the window neither extends nor cancels it
          if (!ce_q) begin
            ce_q <= 1'b1;
            ce_cnt_q <= ce_last[2:0];
          end
        end else if (!wd[`SCP_DIV_CE_BIT] && ce_q) begin
          sel_q <= wd[3:0];
          pend_q <= 1'b1;
          ce_q <= 1'b0;
        end
      end
      if (wr_trim) begin
        trim_q <= wd;
      end
      if (wr_async) begin
        osc_req_q <= wd[`SCP_ASY_OSC_BIT];
        ext_req_q <= wd[`SCP_ASY_EXT_BIT];
      end
    end
  end

  assign rc_trim = trim_q;

  // ----------------------------------------------------------------
  // Timer oscillator pins
  // ----------------------------------------------------------------
  // Pins are shared with the main oscillator, so only the RC source
  // leaves them free; the RC rate covers the four-times margin
  assign timer_osc_xtal_en = src_rc_sel & osc_req_q & ~ext_req_q;
  assign timer_osc_ext_sel = src_rc_sel & ext_req_q;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  reg [3:0] act_q;
  reg [7:0] cnt_q;
  reg div_clk_q;
  // Reserved codes above 8 divide by 256
  wire [3:0] eff = (sel_q > `SCP_DIV_MAX_CODE) ? `SCP_DIV_MAX_CODE : sel_q;
  wire [7:0] half_m1 = (act_q == 4'h0) ? 8'h00 :
                       ((8'h01 << (act_q - 4'h1)) - 8'h01);
  wire term = (cnt_q == half_m1);
  // Switch only where a full old period ends, so the last old period
  // and the first new one are both complete
  assign apply = pend_q & ((act_q == 4'h0) | (term & ~div_clk_q));

  // A counter on the undivided clock stands for the ripple chain; its
  // state is not mapped, since the switch moment is unpredictable anyway
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_q <= 4'h0;
      cnt_q <= 8'h00;
      div_clk_q <= 1'b0;
      sysclk_tick_q <= 1'b0;
    end else if (apply) begin
      act_q <= eff;
      cnt_q <= 8'h00;
      div_clk_q <= (eff != 4'h0);
      sysclk_tick_q <= 1'b1;
    end else if (act_q == 4'h0) begin
      cnt_q <= 8'h00;
      div_clk_q <= 1'b0;
      sysclk_tick_q <= 1'b1;
    end else if (term) begin
      cnt_q <= 8'h00;
      div_clk_q <= ~div_clk_q;
      sysclk_tick_q <= ~div_clk_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      sysclk_tick_q <= 1'b0;
    end
  end

  // Divide by one passes the source itself; the mux changes only just
  // after a rising edge while the source is high; the divided input is high when leaving divide by one, low when entering it
  assign sysclk_out = (act_q == 4'h0) ? core_clk : div_clk_q;

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  assign clock_output_pin_o = clock_output_fuse ? sysclk_out : gpio_out;
  assign clock_output_pin_oe = clock_output_fuse | gpio_oe;

  // ----------------------------------------------------------------
  // Reset delay and wake-up delay
  // ----------------------------------------------------------------
  localparam ST_BASE = 2'h0;
  localparam ST_EXTRA = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] st_q;
  reg [23:0] dly_q;
  reg [2:0] wake_q;
  reg waking_q;

  // Short option length depends on source; 128 kHz uses the 4 ms figure
  wire [23:0] t_short = src_lf_sel ? DLY_4MS : DLY_4P1MS;
  reg [23:0] t_extra;
  always @* begin
    case (startup_time_fuses)
      `SCP_SUT_BASE: begin
        t_extra = reset_pin_disable_fuse ? t_short : 24'h000000;
      end
      `SCP_SUT_FAST: begin
        t_extra = t_short;
      end
      `SCP_SUT_SLOW: begin
        t_extra = DLY_65MS;
      end
      default: begin
        t_extra = 24'h000000;
      end
    endcase
  end

  // The time-out counts undivided edges, independent of the prescaler
  // and of software, like a separate watchdog oscillator would
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_BASE;
      dly_q <= 24'h000000;
      core_rst_n_q <= 1'b0;
    end else begin
      case (st_q)
        ST_BASE: begin
          if (dly_q == `SCP_BASE_CK - 1) begin
            dly_q <= 24'h000000;
            if (t_extra == 24'h000000) begin
              st_q <= ST_RUN;
              core_rst_n_q <= 1'b1;
            end else begin
              st_q <= ST_EXTRA;
            end
          end else begin
            dly_q <= dly_q + 24'h000001;
          end
        end
        ST_EXTRA: begin
          if (dly_q == t_extra - 24'h000001) begin
            st_q <= ST_RUN;
            core_rst_n_q <= 1'b1;
          end else begin
            dly_q <= dly_q + 24'h000001;
          end
        end
        ST_RUN: begin
          core_rst_n_q <= 1'b1;
        end
        default: begin
          st_q <= ST_BASE;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_q <= 3'h0;
      waking_q <= 1'b0;
      wake_done_q <= 1'b0;
    end else begin
      wake_done_q <= 1'b0;
      if (waking_q) begin
        if (wake_q == `SCP_WAKE_CK - 1) begin
          waking_q <= 1'b0;
          wake_done_q <= 1'b1;
        end else begin
          wake_q <= wake_q + 3'h1;
        end
      end else if (wake_req) begin
        waking_q <= 1'b1;
        wake_q <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Muxed from flops on the latched address so a read just after a
  // write to the same register sees the new value
  reg [31:0] rdat;
  always @* begin
    rdat = 32'h00000000;
    if (rd_q) begin
      case (addr_q)
        `SCP_OFS_DIVIDER: begin
          rdat[7:0] = {ce_q, 3'b000, sel_q};
        end
        `SCP_OFS_TRIM: begin
          rdat[7:0] = trim_q;
        end
        `SCP_OFS_ASYNC: begin
          rdat[`SCP_ASY_OSC_BIT] = osc_req_q;
          rdat[`SCP_ASY_EXT_BIT] = ext_req_q;
        end
        `SCP_OFS_STATUS: begin
          rdat[3:0] = act_q;
          rdat[`SCP_ST_PEND_BIT] = pend_q;
          rdat[`SCP_ST_RUN_BIT] = core_rst_n_q;
          rdat[`SCP_ST_SRC_LSB+1:`SCP_ST_SRC_LSB] = src_code;
        end
        default: begin
          rdat = 32'h00000000;
        end
      endcase
    end
  end
  assign hrdata = rdat;

endmodule // scp_top
`default_nettype wire

/* File: testbench/scp_asserts.sv */
// Port-level checks for the clock source and prescaler block
`timescale 1ns/10ps
`default_nettype none
module scp_asserts #(
  parameter [23:0] DLY_4P1MS = 24'h14,
  parameter [23:0] DLY_4MS = 24'h12,
  parameter [23:0] DLY_65MS = 24'h28
) (
  // Clock, reset and fuses
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic reset_pin_disable_fuse,
  input wire logic clock_output_fuse,
  input wire logic [7:0] factory_trim,
  // Core control
  input wire logic wake_req,
  input wire logic wake_done_q,
  input wire logic core_rst_n_q,
  input wire logic src_rc_sel,
  input wire logic src_lf_sel,
  input wire logic src_ext_sel,
  input wire logic [7:0] rc_trim,
  // Pins
  input wire logic sysclk_out,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_pin_oe,
  input wire logic timer_osc_xtal_en,
  input wire logic timer_osc_ext_sel
);
  // ------------------------------------------------------------
  // Reset delay reference
  // ------------------------------------------------------------
  wire [3:0] cs = clock_source_select_fuses;
  logic [23:0] cnt_q;
  logic [23:0] shrt;
  logic [23:0] extra;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 24'h0;
    end else begin
      cnt_q <= cnt_q + 24'h1;
    end
  end
  // Reserved start-up code adds no extra delay, even with the reset pin off
  always @* begin
    shrt = (cs == 4'h3) ? DLY_4MS : DLY_4P1MS;
    case (startup_time_fuses)
      2'h0: extra = reset_pin_disable_fuse ? shrt : 24'h0;
      2'h1: extra = shrt;
      2'h2: extra = DLY_65MS;
      default: extra = 24'h0;
    endcase
  end
  src_rc_a:
    assert property (src_rc_sel == (cs == 4'h2))
    else $error("rc source decode wrong");
  src_lf_a:
    assert property (src_lf_sel == (cs == 4'h3))
    else $error("low rate source decode wrong");
  src_ext_a:
    assert property (src_ext_sel == (cs == 4'h0))
    else $error("external source decode wrong");
  trim_load_a:
    assert property (!$past(nrst) |=> rc_trim == factory_trim)
    else $error("trim not loaded after reset");
  wake_time_a:
    assert property (wake_done_q |-> $past(wake_req, 7) ##1 !wake_done_q)
    else $error("wake delay wrong");
  rst_delay_a:
    assert property ($rose(core_rst_n_q) |-> cnt_q == extra + 24'h13)
    else $error("reset delay wrong");
  pin_clock_a:
    assert property (clock_output_fuse |-> clock_output_pin_oe &&
      clock_output_pin_o == sysclk_out)
    else $error("clock pin not driven by system clock");
  pin_port_a:
    assert property (!clock_output_fuse |-> clock_output_pin_oe == gpio_oe
      && clock_output_pin_o == gpio_out)
    else $error("clock pin port function lost");
  tmr_ext_a:
    assert property (timer_osc_ext_sel |-> src_rc_sel)
    else $error("timer clock input without rc source");
  tmr_xtal_a:
    assert property (timer_osc_xtal_en |-> src_rc_sel && !timer_osc_ext_sel)
    else $error("timer crystal enable wrong");
  cover property ($rose(core_rst_n_q));
  cover property (wake_done_q);
  cover property (clock_output_fuse && clock_output_pin_oe);
endmodule  // scp_asserts
bind scp_top scp_asserts #(.DLY_4P1MS(DLY_4P1MS), .DLY_4MS(DLY_4MS),
  .DLY_65MS(DLY_65MS)) u_chk (.*);
`default_nettype wire

/* File: testbench/scp_board.sv */
// Board model: fuse array, factory trim and clock pin port use
`timescale 1ns/10ps
`default_nettype none
module scp_board #(
  parameter logic [7:0] TRIM = 8'h5A
) (
  // Clock, reset and board settings
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [8:0] cfg,
  // Fuses: clock out, div8, reset pin off, start-up, source
  output logic [8:0] fz,
  output logic [7:0] trim,
  // Normal port use of the clock pin
  output logic gpio_out,
  output logic gpio_oe
);
  // ------------------------------------------------------------
  // Fuses and pin traffic
  // ------------------------------------------------------------
  // Source only moves under reset, so no large rate jump hits a core
  always @(posedge core_clk) begin
    if (!nrst) begin
      fz <= cfg;
    end
  end
  assign trim = TRIM;
  assign gpio_oe = ~gpio_out;
  // Toggling each cycle exposes a pin mux stuck on either input
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gpio_out <= 1'b0;
    end else begin
      gpio_out <= ~gpio_out;
    end
  end
endmodule  // scp_board
`default_nettype wire

/* File: testbench/system_clock_source_and_prescaler_test.sv */
// Self-checking bench for the clock source and prescaler block
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(c) n = 0; \
  do begin \
    @(posedge core_clk); \
    #1; \
    n++; \
  end while ((c) !== 1'b1 && n < 900); \
  lim(n);
module system_clock_source_and_prescaler_test;
  // ------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------
  localparam logic [7:0] DV = `SCP_OFS_DIVIDER;
  localparam logic [7:0] AS = `SCP_OFS_ASYNC;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic wake_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd_q = 32'h0;
  logic [31:0] r;
  logic [8:0] cfg = 9'h002;
  wire hreadyout, hresp, wake_done_q, core_rst_n_q, src_rc_sel, src_lf_sel;
  wire src_ext_sel, sysclk_out, sysclk_tick_q, gpio_out, gpio_oe;
  wire clock_output_pin_o, clock_output_pin_oe, timer_osc_xtal_en;
  wire timer_osc_ext_sel;
  wire [31:0] hrdata;
  wire [7:0] rc_trim, trim;
  wire [8:0] fz;
  int err_count = 0;
  int cmp_count = 0;
  int n, i;
  logic [8:0] cf [7] = '{9'h000, 9'h012, 9'h043, 9'h023, 9'h032, 9'h142,
    9'h082};
  int dly [7] = '{19, 39, 37, 59, 19, 39, 19};
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) rd_q <= hrdata;
  scp_top #(.DLY_4P1MS(24'h14), .DLY_4MS(24'h12), .DLY_65MS(24'h28)) dut (
    .*, .hsize(3'h2), .hready(hreadyout), .factory_trim(trim),
    .clock_source_select_fuses(fz[3:0]), .startup_time_fuses(fz[5:4]),
    .reset_pin_disable_fuse(fz[6]), .divide_by_eight_fuse(fz[7]),
    .clock_output_fuse(fz[8]));
  scp_board #(.TRIM(8'h5A)) u_brd (.*);
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A wait that runs out of its bound ends the run
  task automatic lim(input int k);
    if (k >= 900) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    `WAIT(hreadyout)
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    `WAIT(hreadyout)
    r = rd_q;
  endtask
  task automatic boot(input logic [8:0] c, input int e);
    nrst <= 1'b0;
    cfg <= c;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    `WAIT(core_rst_n_q)
    `CHK(n, e)
  endtask
  // Back to back, so nothing can slip between the two writes
  task automatic setdiv(input logic [3:0] c);
    xfer(1'b1, DV, 32'h80);
    xfer(1'b1, DV, {28'h0, c});
  endtask
  // First ticks may still span the old rate, so time the third
  task automatic period(input int e);
    repeat (3) begin
      `WAIT(sysclk_tick_q)
    end
    `CHK(n, e)
  endtask
  initial begin
    for (i = 0; i < 7; i++) begin
      boot(cf[i], dly[i]);
      `CHK(src_rc_sel, cf[i][3:0] == 4'h2)
      `CHK(src_lf_sel, cf[i][3:0] == 4'h3)
      `CHK(src_ext_sel, cf[i][3:0] == 4'h0)
      xfer(1'b0, `SCP_OFS_TRIM, 32'h0);
      `CHK(r[7:0], 8'h5A)
      xfer(1'b0, DV, 32'h0);
      `CHK(r[3:0], cf[i][7] ? 4'h3 : 4'h0)
      `CHK(clock_output_pin_oe, cf[i][8] | gpio_oe)
    end
    period(8);
    setdiv(4'hC);
    period(256);
    for (i = 0; i < 9; i++) begin
      setdiv(i[3:0]);
      period(1 << i);
    end
    // Enable at E; a rewrite at E+4 falls in the last window cycle, so
    // the select write at E+6 only lands if the rewrite extended it
    xfer(1'b1, DV, 32'h80);
    xfer(1'b0, DV, 32'h0);
    `CHK(r[7], 1'b1)
    xfer(1'b1, DV, 32'h80);
    xfer(1'b1, DV, 32'h01);
    xfer(1'b1, DV, 32'h81);
    xfer(1'b1, DV, 32'h02);
    xfer(1'b0, DV, 32'h0);
    `CHK(r[7:0], 8'h08)
    // A select write in the fourth cycle of the window still lands
    xfer(1'b1, DV, 32'h80);
    xfer(1'b0, DV, 32'h0);
    xfer(1'b1, DV, 32'h05);
    xfer(1'b0, DV, 32'h0);
    `CHK(r[7:0], 8'h05)
    wake_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    `WAIT(wake_done_q)
    `CHK(n, 6)
    xfer(1'b1, AS, 32'h2);
    `CHK(timer_osc_ext_sel, 1'b1)
    xfer(1'b1, AS, 32'h1);
    `CHK(timer_osc_xtal_en, 1'b1)
    xfer(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    boot(9'h100, 19);
    xfer(1'b1, AS, 32'h3);
    `CHK(timer_osc_ext_sel, 1'b0)
    `CHK(timer_osc_xtal_en, 1'b0)
    tally_and_finish();
  end
endmodule  // system_clock_source_and_prescaler_test
`default_nettype wire
